// ===== common/freq_cmd_pkg.sv
package freq_cmd_pkg;

  // ------------------------------------------------------------
  // frequency and value formats
  // ------------------------------------------------------------
  // frequencies in 0.1 Hz steps, 12 bits covers 0..360.0 Hz
  localparam int FW = 12;
  localparam int PW = 12;             // process values, 0..4095 full span
  localparam logic [FW-1:0] FREQ_360 = 12'he10;   // 360.0 Hz
  localparam logic [FW-1:0] FREQ_0P5 = 12'h005;   // 0.5 Hz
  localparam logic [FW-1:0] FREQ_0P1 = 12'h001;   // 0.1 Hz
  localparam logic [FW-1:0] FREQ_10 = 12'h064;    // 10.0 Hz

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_START_FREQ = 8'h04;
  localparam logic [7:0] OFS_END_FREQ = 8'h08;
  localparam logic [7:0] OFS_UPPER_LIM = 8'h0c;
  localparam logic [7:0] OFS_LOWER_LIM = 8'h10;
  localparam logic [7:0] OFS_SKIP_F1 = 8'h14;
  localparam logic [7:0] OFS_SKIP_W1 = 8'h18;
  localparam logic [7:0] OFS_SKIP_F2 = 8'h1c;
  localparam logic [7:0] OFS_SKIP_W2 = 8'h20;
  localparam logic [7:0] OFS_SKIP_F3 = 8'h24;
  localparam logic [7:0] OFS_SKIP_W3 = 8'h28;
  localparam logic [7:0] OFS_KP = 8'h2c;
  localparam logic [7:0] OFS_TI = 8'h30;
  localparam logic [7:0] OFS_KD = 8'h34;
  localparam logic [7:0] OFS_KEYPAD_SP = 8'h38;
  localparam logic [7:0] OFS_SCALE = 8'h3c;
  localparam logic [7:0] OFS_FB_SPAN = 8'h40;
  localparam logic [7:0] OFS_FIXED_BASE = 8'h80;  // 16 words to 0xbc
  localparam logic [7:0] OFS_STATUS = 8'hc0;
  localparam logic [7:0] OFS_DISP = 8'hc4;

  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;   // 2 bits
  localparam int CTRL_SRC_LSB = 2;    // 2 bits, setpoint source
  localparam int CTRL_AN_CUR = 4;     // analog setpoint is 4-20 mA
  localparam int CTRL_FB_CUR = 5;     // feedback is current input

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [FW-1:0] RST_LIMIT = 12'h000;  // 0.0 = off
  localparam logic [FW-1:0] RST_SKIP_F = 12'h000;
  localparam logic [FW-1:0] RST_SKIP_W = 12'h005; // 0.5 Hz
  localparam logic [FW-1:0] RST_START = 12'h005;
  localparam logic [FW-1:0] RST_END = 12'h1f4;    // 50.0 Hz
  localparam logic [7:0] RST_KP = 8'h0a;          // 1.0, 0.1 steps
  localparam logic [7:0] KP_MIN = 8'h02;          // 0.2
  localparam logic [7:0] KP_MAX = 8'h32;          // 5.0
  localparam logic [11:0] RST_TI = 12'h000;       // 0.0 = no integral
  localparam logic [11:0] TI_MIN = 12'h005;       // 0.5 s, 0.1 s steps
  localparam logic [11:0] TI_MAX = 12'h5dc;       // 150.0 s
  localparam logic [11:0] RST_KD = 12'h000;
  localparam logic [11:0] KD_MAX = 12'h3e8;       // 100.0 s
  localparam logic [15:0] RST_SCALE = 16'h0100;   // 1.0 in 8.8
  localparam logic [PW-1:0] RST_SPAN = 12'hfff;
  localparam logic [PW-1:0] CUR_4MA = 12'h333;    // 4 mA of 20 mA span

  // ------------------------------------------------------------
  // timing: regulator sample interval
  // ------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int SAMPLE_MS = 10;
  localparam int SAMPLE_CYC = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int SAMPLES_PER_DS = 10;   // samples per 0.1 s

  typedef enum logic [1:0] {
    MODE_FREQ = 2'b00,
    MODE_PID = 2'b01
  } mode_t;

  typedef enum logic [1:0] {
    SRC_KEYPAD = 2'b00,
    SRC_FIXED = 2'b01,
    SRC_ANALOG = 2'b10
  } sp_src_t;

  typedef struct packed {
    logic [FW-1:0] freq;
    logic [FW-1:0] width;
  } skip_band_t;

  typedef struct packed {
    logic [PW-1:0] voltage;
    logic [PW-1:0] current;
  } analog_in_t;

endpackage : freq_cmd_pkg

// ===== hdl/freq_limit_skip_pid.sv
// Functional notes
// [R1] On start, output jumps at once to the lower operating limit.
// [R2] Upper and lower limits narrow the start..end frequency range.
// [R3] Upper limit spans 0.5..360 Hz, default 0.0, zero disables it.
// [R4] Three skip frequencies 0.1..360 Hz, default 0.0, avoid resonance.
// [R5] Each skip band has own width 0.1..10 Hz, default 0.5.
// [R6] Inside a skip band, output holds the nearer band edge.
// [R7] Setpoint from keypad or one of sixteen fixed values by inputs.
// [R8] Setpoint may come from analog 0-10 V or 4-20 mA input.
// [R9] Feedback from voltage or current input, span is configurable.
// [R10] Setpoint and feedback are scaled for display in process units.
// [R11] Closed-loop mode drives setpoint minus feedback toward zero by PID.
// [R12] Operator sets setpoint and feedback source before closed loop.
// [R13] Proportional gain 0.2..5.0 scales the control error.
// [R14] Maximum output frequency counts as 100 percent of regulator range.
// [R15] Integral time 0.5..150 s accumulates error; 0.0 disables it.
// [R16] Derivative coefficient 0..100 s acts on error rate of change.
// [R17] P, I and D contributions sum into one frequency correction.
// [R18] Derivative best left unused for flow, pressure, temperature.
// [R19] Operator keeps PID settings inside the stable region.
// [R20] Mode 00 is plain frequency control, 01 is closed-loop PID.
// [R21] Regulator output still passes limits and skip bands.
`timescale 1ns/100ps
module freq_limit_skip_pid #(
  parameter int SAMPLE_CYCLES = freq_cmd_pkg::SAMPLE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // run control and setpoint sources (pins)
  input wire logic run_i,
  input wire logic [3:0] fixed_sel_i,
  input wire logic [freq_cmd_pkg::FW-1:0] freq_request_i,
  input wire freq_cmd_pkg::analog_in_t sp_analog_i,
  input wire freq_cmd_pkg::analog_in_t fb_analog_i,
  // power stage
  output logic [freq_cmd_pkg::FW-1:0] out_freq_o,
  output logic running_o
);
  import freq_cmd_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [FW-1:0] clamp_f(input logic [FW-1:0] v,
      input logic [FW-1:0] lo, input logic [FW-1:0] hi);
    logic [FW-1:0] r;
    r = (v < lo) ? lo : v;
    r = (r > hi) ? hi : r;
    return r;
  endfunction : clamp_f

  // keep a setting inside its documented range on write
  function automatic logic [11:0] wr_range(input logic [31:0] d,
      input logic [11:0] lo, input logic [11:0] hi, input logic zero_ok);
    logic [11:0] v;
    v = (d[31:12] != 20'h0) ? hi : d[11:0];
    if (zero_ok && v == 12'h000) begin
      return v;
    end
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : wr_range

  // skip band: move a request inside the band to the nearer edge
  function automatic logic [FW-1:0] skip(input logic [FW-1:0] v,
      input skip_band_t b);
    logic [FW:0] lo;
    logic [FW:0] hi;
    lo = {1'b0, b.freq} - {1'b0, b.width};
    hi = {1'b0, b.freq} + {1'b0, b.width};
    if (b.freq == 12'h000 || lo[FW]) begin
      return v;
    end
    if ({1'b0, v} > lo && {1'b0, v} < hi) begin
      return (v < b.freq) ? lo[FW-1:0] : hi[FW-1:0];
    end
    return v;
  endfunction : skip

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [5:0] ctrl_ff;
  logic [FW-1:0] start_freq_ff, end_freq_ff;
  logic [FW-1:0] upper_operating_limit_ff, lower_operating_limit_ff;
  skip_band_t band_ff [3];
  logic [7:0] proportional_gain_setting_ff;
  logic [11:0] ti_ff, kd_ff;
  logic [FW-1:0] keypad_sp_ff;
  logic [15:0] scale_ff;
  logic [PW-1:0] fb_span_ff;
  logic [PW-1:0] fixed_sp_ff [16];
  logic ack_ff;
  logic [31:0] rd_ff;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [4:0] pin_s1_ff, pin_s2_ff;
  logic [FW-1:0] req_s1_ff, req_s2_ff;
  analog_in_t sp_s1_ff, sp_s2_ff, fb_s1_ff, fb_s2_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    pin_s1_ff <= {run_i, fixed_sel_i};
    pin_s2_ff <= pin_s1_ff;
    req_s1_ff <= freq_request_i;
    req_s2_ff <= req_s1_ff;
    sp_s1_ff <= sp_analog_i;
    sp_s2_ff <= sp_s1_ff;
    fb_s1_ff <= fb_analog_i;
    fb_s2_ff <= fb_s1_ff;
  end

  wire run_s = pin_s2_ff[4];
  wire [3:0] fixed_idx = pin_s2_ff[3:0];
  wire mode_t mode = mode_t'(ctrl_ff[CTRL_MODE_LSB +: 2]);
  wire sp_src_t src = sp_src_t'(ctrl_ff[CTRL_SRC_LSB +: 2]);

  // ------------------------------------------------------------
  // setpoint and feedback conditioning
  // ------------------------------------------------------------
  // 4-20 mA: strip the 4 mA live zero and stretch to full span
  function automatic logic [PW-1:0] live_zero(input logic [PW-1:0] v);
    logic [PW:0] d;
    logic [PW+12:0] p;
    d = (v > CUR_4MA) ? {1'b0, v - CUR_4MA} : '0;
    p = {12'h0, d} * 25'd5;
    return (p[PW+12:2] > 23'(RST_SPAN)) ? RST_SPAN : PW'(p[PW+12:2]);
  endfunction : live_zero

  // [R8] analog setpoint range
  wire [PW-1:0] an_sp = ctrl_ff[CTRL_AN_CUR] ?
      live_zero(sp_s2_ff.current) : sp_s2_ff.voltage;
  // [R9] feedback source and span
  wire [PW-1:0] fb_raw = ctrl_ff[CTRL_FB_CUR] ?
      live_zero(fb_s2_ff.current) : fb_s2_ff.voltage;
  wire [PW-1:0] fb_val = (fb_raw > fb_span_ff) ? fb_span_ff : fb_raw;
  // [R7] keypad or sixteen fixed setpoints
  wire [PW-1:0] sp_val = (src == SRC_FIXED) ? fixed_sp_ff[fixed_idx] :
      (src == SRC_ANALOG) ? an_sp : keypad_sp_ff;
  // [R10] display scaling, 8.8 fixed point
  wire [27:0] sp_disp_w = {16'h0, sp_val} * {12'h0, scale_ff};
  wire [27:0] fb_disp_w = {16'h0, fb_val} * {12'h0, scale_ff};

  // ------------------------------------------------------------
  // pid regulator, one step per sample tick
  // ------------------------------------------------------------
  logic [31:0] tick_cnt_ff;
  logic signed [31:0] integ_ff;
  logic signed [13:0] prev_err_ff;
  logic signed [31:0] pid_ff;
  wire tick = (tick_cnt_ff == 32'(SAMPLE_CYCLES - 1));

  // [R11] control error
  wire signed [13:0] err = $signed({2'b00, sp_val}) -
      $signed({2'b00, fb_val});
  // [R13] proportional term, gain in 0.1 steps
  // operands widen to 32 bits first so no product loses its top bits
  wire signed [31:0] p_term = 32'(err) *
      $signed(32'(proportional_gain_setting_ff)) / 32'sd10;
  // [R15] integral step err*T/Ti, Ti in 0.1 s units; zero Ti disables
  // divisor kept signed, else a negative error divides as unsigned
  wire signed [31:0] i_step = (ti_ff == 12'h000) ? 32'sd0 :
      32'(err) / ($signed(32'(ti_ff)) * 32'(SAMPLES_PER_DS));
  wire signed [31:0] integ_nxt = integ_ff + i_step;
  // [R16] derivative term kd*de/dt
  wire signed [31:0] d_term = 32'(err - prev_err_ff) *
      $signed(32'(kd_ff)) * 32'(SAMPLES_PER_DS);
  // [R17] one combined correction
  wire signed [31:0] pid_sum = p_term + integ_nxt + d_term;
  // [R14] full process span maps to the maximum output frequency
  wire signed [31:0] pid_hz = pid_sum * $signed(32'(end_freq_ff)) /
      32'sd4095;

  // sample divider and pid state; state clears outside closed-loop run
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_s || mode != MODE_PID) begin
      tick_cnt_ff <= 32'h0;
      integ_ff <= 32'sh0;
      prev_err_ff <= 14'sh0;
      pid_ff <= 32'sh0;
    end else begin
      tick_cnt_ff <= tick ? 32'h0 : tick_cnt_ff + 32'h1;
      if (tick) begin
        integ_ff <= integ_nxt;
        prev_err_ff <= err;
        pid_ff <= pid_hz;
      end
    end
  end

  // ------------------------------------------------------------
  // limits and skip bands
  // ------------------------------------------------------------
  // [R20] mode picks plain request or regulator output
  wire [FW-1:0] raw_req = (mode == MODE_PID) ?
      ((pid_ff < 0) ? 12'h000 : (pid_ff > 32'(FREQ_360)) ? FREQ_360 :
      pid_ff[FW-1:0]) : req_s2_ff;
  // [R2] effective bounds; [R3] zero upper limit means no limit
  wire [FW-1:0] hi_b = (upper_operating_limit_ff != 12'h000 &&
      upper_operating_limit_ff < end_freq_ff) ?
      upper_operating_limit_ff : end_freq_ff;
  wire [FW-1:0] lo_b = (lower_operating_limit_ff > start_freq_ff) ?
      lower_operating_limit_ff : start_freq_ff;
  // [R21] regulator result also clamped and skipped
  wire [FW-1:0] clamped = clamp_f(raw_req, lo_b, hi_b);
  // [R4] [R6] three bands applied in turn
  wire [FW-1:0] skip1 = skip(clamped, band_ff[0]);
  wire [FW-1:0] skip2 = skip(skip1, band_ff[1]);
  wire [FW-1:0] skip3 = skip(skip2, band_ff[2]);

  // [R1] start applies the lower limit at once, then follows the command
  logic run_d_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_d_ff <= 1'b0;
      out_freq_o <= 12'h000;
    end else begin
      run_d_ff <= run_s;
      if (!run_s) begin
        out_freq_o <= 12'h000;
      end else if (!run_d_ff) begin
        out_freq_o <= lower_operating_limit_ff;
      end else begin
        out_freq_o <= skip3;
      end
    end
  end
  assign running_o = run_d_ff;

  // ------------------------------------------------------------
  // wishbone register file, ack one cycle after request
  // ------------------------------------------------------------
  wire req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire wr = req && wb_we_i && wb_sel_i[0] && wb_sel_i[1];
  wire fix_hit = (wb_adr_i[7:6] == 2'b10);
  wire [3:0] fix_idx = wb_adr_i[5:2];
  wire [31:0] fix_rd = {20'h0, fixed_sp_ff[fix_idx]};

  // read data mux; unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    case (wb_adr_i)
      OFS_CTRL: rd_mux = {26'h0, ctrl_ff};
      OFS_START_FREQ: rd_mux = {20'h0, start_freq_ff};
      OFS_END_FREQ: rd_mux = {20'h0, end_freq_ff};
      OFS_UPPER_LIM: rd_mux = {20'h0, upper_operating_limit_ff};
      OFS_LOWER_LIM: rd_mux = {20'h0, lower_operating_limit_ff};
      OFS_SKIP_F1: rd_mux = {20'h0, band_ff[0].freq};
      OFS_SKIP_W1: rd_mux = {20'h0, band_ff[0].width};
      OFS_SKIP_F2: rd_mux = {20'h0, band_ff[1].freq};
      OFS_SKIP_W2: rd_mux = {20'h0, band_ff[1].width};
      OFS_SKIP_F3: rd_mux = {20'h0, band_ff[2].freq};
      OFS_SKIP_W3: rd_mux = {20'h0, band_ff[2].width};
      OFS_KP: rd_mux = {24'h0, proportional_gain_setting_ff};
      OFS_TI: rd_mux = {20'h0, ti_ff};
      OFS_KD: rd_mux = {20'h0, kd_ff};
      OFS_KEYPAD_SP: rd_mux = {20'h0, keypad_sp_ff};
      OFS_SCALE: rd_mux = {16'h0, scale_ff};
      OFS_FB_SPAN: rd_mux = {20'h0, fb_span_ff};
      OFS_STATUS: rd_mux = {3'h0, run_d_ff, out_freq_o, 4'h0, fb_val};
      OFS_DISP: rd_mux = {sp_disp_w[23:8], fb_disp_w[23:8]};
      default: rd_mux = fix_hit ? fix_rd : 32'h0;
    endcase
  end

  // bus handshake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rd_ff <= 32'h0;
    end else begin
      ack_ff <= req;
      rd_ff <= req ? rd_mux : rd_ff;
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rd_ff;

  // configuration writes, taken on the request edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= 6'h00;
      start_freq_ff <= RST_START;
      end_freq_ff <= RST_END;
      upper_operating_limit_ff <= RST_LIMIT;
      lower_operating_limit_ff <= RST_LIMIT;
      band_ff[0] <= '{RST_SKIP_F, RST_SKIP_W};
      band_ff[1] <= '{RST_SKIP_F, RST_SKIP_W};
      band_ff[2] <= '{RST_SKIP_F, RST_SKIP_W};
      proportional_gain_setting_ff <= RST_KP;
      ti_ff <= RST_TI;
      kd_ff <= RST_KD;
      keypad_sp_ff <= 12'h000;
      scale_ff <= RST_SCALE;
      fb_span_ff <= RST_SPAN;
    end else if (wr) begin
      case (wb_adr_i)
        OFS_CTRL: ctrl_ff <= wb_dat_i[5:0];
        OFS_START_FREQ: start_freq_ff <= wr_range(wb_dat_i, 12'h000,
            FREQ_360, 1'b1);
        OFS_END_FREQ: end_freq_ff <= wr_range(wb_dat_i, 12'h000,
            FREQ_360, 1'b1);
        // [R3] upper limit range with zero allowed
        OFS_UPPER_LIM: upper_operating_limit_ff <= wr_range(wb_dat_i,
            FREQ_0P5, FREQ_360, 1'b1);
        OFS_LOWER_LIM: lower_operating_limit_ff <= wr_range(wb_dat_i,
            FREQ_0P5, FREQ_360, 1'b1);
        // [R4] [R5] band settings held in range
        OFS_SKIP_F1: band_ff[0].freq <= wr_range(wb_dat_i, FREQ_0P1,
            FREQ_360, 1'b1);
        OFS_SKIP_W1: band_ff[0].width <= wr_range(wb_dat_i, FREQ_0P1,
            FREQ_10, 1'b0);
        OFS_SKIP_F2: band_ff[1].freq <= wr_range(wb_dat_i, FREQ_0P1,
            FREQ_360, 1'b1);
        OFS_SKIP_W2: band_ff[1].width <= wr_range(wb_dat_i, FREQ_0P1,
            FREQ_10, 1'b0);
        OFS_SKIP_F3: band_ff[2].freq <= wr_range(wb_dat_i, FREQ_0P1,
            FREQ_360, 1'b1);
        OFS_SKIP_W3: band_ff[2].width <= wr_range(wb_dat_i, FREQ_0P1,
            FREQ_10, 1'b0);
        // [R13] gain held to 0.2..5.0
        OFS_KP: proportional_gain_setting_ff <= 8'(wr_range(wb_dat_i,
            {4'h0, KP_MIN}, {4'h0, KP_MAX}, 1'b0));
        OFS_TI: ti_ff <= wr_range(wb_dat_i, TI_MIN, TI_MAX, 1'b1);
        OFS_KD: kd_ff <= wr_range(wb_dat_i, 12'h000, KD_MAX, 1'b1);
        OFS_KEYPAD_SP: keypad_sp_ff <= wb_dat_i[PW-1:0];
        OFS_SCALE: scale_ff <= wb_dat_i[15:0];
        OFS_FB_SPAN: fb_span_ff <= wb_dat_i[PW-1:0];
        default: ;
      endcase
    end
  end

  // fixed setpoint table, no reset needed for data words
  always_ff @(posedge clk_i) begin
    if (wr && fix_hit) begin
      fixed_sp_ff[fix_idx] <= wb_dat_i[PW-1:0];
    end
  end

endmodule : freq_limit_skip_pid

// ===== sim/freq_cmd_sva.sv
`timescale 1ns/100ps
module freq_cmd_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // run and output
  input wire logic run_i,
  input wire logic [freq_cmd_pkg::FW-1:0] out_freq_o,
  input wire logic running_o
);
  import freq_cmd_pkg::*;
  // a request the slave has not answered yet
  wire req_taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_latency: assert property (req_taken |=> wb_ack_o)
    else $error("bus answer not one cycle after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer longer than one cycle");
  chk_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("bus answer without request");
  // reset clears read data, so skip the edge just after it
  chk_dat_hold: assert property (!wb_ack_o && !$past(rst_i) |->
    $stable(wb_dat_o)) else $error("read data moved between answers");
  chk_unmapped_zero: assert property (req_taken && !wb_we_i &&
    wb_adr_i inside {[8'h44:8'h7c]} |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_run_latency: assert property ($rose(run_i) ##0 !running_o
    ##1 run_i [*2] |-> !running_o ##1 running_o)
    else $error("run start latency wrong");
  chk_stop_latency: assert property ($fell(run_i) ##1 !run_i [*2]
    |-> ##1 !running_o) else $error("run stop latency wrong");
  chk_idle_zero: assert property (!running_o && !$past(running_o)
    |-> out_freq_o == '0) else $error("output nonzero while stopped");
  chk_freq_ceiling: assert property (out_freq_o <= FREQ_360)
    else $error("output above top of range");
endmodule : freq_cmd_sva

bind freq_limit_skip_pid freq_cmd_sva u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .run_i(run_i), .out_freq_o(out_freq_o), .running_o(running_o));

// ===== sim/process_plant_model.sv
`timescale 1ns/100ps
module process_plant_model #(
  parameter int LAG = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // drive frequency in, transducer reading out
  input wire logic [freq_cmd_pkg::FW-1:0] out_freq_i,
  output freq_cmd_pkg::analog_in_t fb_o
);
  import freq_cmd_pkg::*;
  int pv_ff;
  int tgt;
  // four codes per 0.1 Hz, saturating at full scale
  assign tgt = (int'(out_freq_i) * 4 > 4095) ? 4095 : int'(out_freq_i) * 4;
  // first order lag; a large LAG makes a slow process
  always_ff @(posedge clk_i) begin
    pv_ff <= rst_i ? 0 : pv_ff + (tgt - pv_ff) / LAG;
  end
  // both transducer outputs carry the reading
  assign fb_o = '{voltage: pv_ff[11:0], current: pv_ff[11:0]};
endmodule : process_plant_model

// ===== sim/tb_freq_limit_skip_pid.sv
`timescale 1ns/100ps
module tb_freq_limit_skip_pid;
  import freq_cmd_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, run_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0, fixed_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [FW-1:0] freq_request_i = 12'h000, out_freq_o;
  logic running_o;
  analog_in_t sp_analog_i = '0, fb_analog_i;
  logic [15:0] lfsr_q = 16'h002a;
  int n_fail = 0, num_checks = 0, cyc_cnt = 0, k;
  int cfg_start = 5, cfg_end = 500, cfg_up = 0, cfg_lo = 0;
  int sf [3] = '{0, 0, 0};
  int sw [3] = '{5, 5, 5};
  logic [7:0] rst_ofs [14] = '{OFS_START_FREQ, OFS_END_FREQ, OFS_UPPER_LIM,
    OFS_LOWER_LIM, OFS_SKIP_F1, OFS_SKIP_W1, OFS_SKIP_F2, OFS_SKIP_W2,
    OFS_SKIP_F3, OFS_SKIP_W3, OFS_KP, OFS_TI, OFS_SCALE, 8'h44};
  int rst_val [14] = '{5, 500, 0, 0, 0, 5, 0, 5, 0, 5, 10, 0, 256, 0};
  logic [7:0] cfg_ofs [9] = '{OFS_UPPER_LIM, OFS_LOWER_LIM, OFS_SKIP_F1,
    OFS_SKIP_W1, OFS_SKIP_F2, OFS_SKIP_W2, OFS_SKIP_F3, OFS_SKIP_W3, OFS_KP};
  int cfg_val [9] = '{400, 100, 150, 10, 250, 10, 350, 20, 10};
  int bnd [9] = '{0, 140, 141, 150, 159, 160, 260, 512, 4095};

  always #50 clk_i = ~clk_i;

  freq_limit_skip_pid #(.SAMPLE_CYCLES(10)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .run_i(run_i), .fixed_sel_i(fixed_sel_i),
    .freq_request_i(freq_request_i), .sp_analog_i(sp_analog_i),
    .fb_analog_i(fb_analog_i), .out_freq_o(out_freq_o),
    .running_o(running_o));
  process_plant_model plant (.clk_i(clk_i), .rst_i(rst_i),
    .out_freq_i(out_freq_o), .fb_o(fb_analog_i));

  // ----------------------------------------------------------
  // reference model and helpers
  // ----------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // limits first, then each skip band pushes out to its nearer edge
  function automatic int cmd_model(input int v);
    int lo;
    int hi;
    lo = (cfg_lo > cfg_start) ? cfg_lo : cfg_start;
    hi = (cfg_up != 0 && cfg_up < cfg_end) ? cfg_up : cfg_end;
    if (v < lo) v = lo;
    if (v > hi) v = hi;
    for (int i = 0; i < 3; i++) begin
      if (sf[i] != 0 && sf[i] >= sw[i] && v > sf[i] - sw[i] &&
          v < sf[i] + sw[i]) v = (v < sf[i]) ? sf[i] - sw[i] : sf[i] + sw[i];
    end
    return v;
  endfunction : cmd_model

  task check(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // one classic cycle; release only at the edge that saw ack
  task xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : xfer

  // write and mirror limits and bands into the model
  task wr(input logic [7:0] a, input int v);
    xfer(1'b1, a, 32'(v), 4'hf);
    if (a == OFS_START_FREQ) cfg_start = v;
    if (a == OFS_UPPER_LIM) cfg_up = v;
    if (a == OFS_LOWER_LIM) cfg_lo = v;
    if (a >= OFS_SKIP_F1 && a <= OFS_SKIP_W3) begin
      if (a[2]) sf[(a - OFS_SKIP_F1) / 8] = v;
      else sw[(a - OFS_SKIP_F1) / 8] = v;
    end
  endtask : wr

  // two sync flops plus the output register
  task set_req(input int v);
    @(posedge clk_i);
    freq_request_i <= 12'(v);
    repeat (4) @(posedge clk_i);
    #1;
    check("out_freq", 32'(out_freq_o), 32'(cmd_model(v)));
  endtask : set_req

  // hang guard
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      xfer(1'b0, rst_ofs[i], 32'h0, 4'hf);
      check("reset value", rd, 32'(rst_val[i]));
    end
    xfer(1'b1, OFS_KP, 32'h64, 4'hf);
    xfer(1'b0, OFS_KP, 32'h0, 4'hf);
    check("gain clamp", rd, 32'(KP_MAX));
    wr(OFS_SKIP_W1, 0);
    xfer(1'b0, OFS_SKIP_W1, 32'h0, 4'hf);
    check("width clamp", rd, 32'(FREQ_0P1));
    xfer(1'b1, OFS_LOWER_LIM, 32'hc8, 4'b1100);
    xfer(1'b0, OFS_LOWER_LIM, 32'h0, 4'hf);
    check("lane refusal", rd, 32'h0);
    for (int i = 0; i < 9; i++) wr(cfg_ofs[i], cfg_val[i]);
    // start jumps to the lower limit before following the request
    @(posedge clk_i);
    freq_request_i <= 12'h0c8;
    run_i <= 1'b1;
    for (k = 0; k < 10 && running_o !== 1'b1; k++) begin
      @(posedge clk_i);
      #1;
    end
    check("start freq", 32'(out_freq_o), 32'(cfg_lo));
    @(posedge clk_i);
    #1;
    check("first cmd", 32'(out_freq_o), 32'(cmd_model(200)));
    for (int i = 0; i < 9; i++) set_req(bnd[i]);
    for (int i = 0; i < 24; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      @(posedge clk_i);
      sp_analog_i <= {lfsr_q[11:0], lfsr_q[15:4]};
      fixed_sel_i <= lfsr_q[15:12];
      set_req(int'(lfsr_q[8:0]));
    end
    wr(OFS_UPPER_LIM, 0);
    set_req(4095);
    // keypad setpoint and voltage feedback chosen before the loop closes;
    // derivative stays off and gains are modest
    wr(OFS_KEYPAD_SP, 12'h300);
    wr(OFS_TI, 5);
    wr(OFS_CTRL, 1);
    repeat (3000) @(posedge clk_i);
    #1;
    check("pid lift", 32'(out_freq_o > 12'(cfg_lo)), 32'h1);
    check("pid limits", 32'(out_freq_o),
      32'(cmd_model(int'(out_freq_o))));
    // keypad setpoint at unity scale shows unchanged on the display
    xfer(1'b0, OFS_DISP, 32'h0, 4'hf);
    check("display sp", rd[31:16], 32'h300);
    // fixed table entry picked by the select pins becomes the setpoint
    wr(OFS_FIXED_BASE + {fixed_sel_i, 2'b00}, 12'h200);
    wr(OFS_CTRL, 5);
    xfer(1'b0, OFS_DISP, 32'h0, 4'hf);
    check("fixed sp", rd[31:16], 32'h200);
    wr(OFS_CTRL, 0);
    set_req(200);
    @(posedge clk_i);
    run_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    check("stopped", 32'(out_freq_o), 32'h0);
    wrap_up();
  end
endmodule : tb_freq_limit_skip_pid
